// ### amcc_checker.sv
`timescale 1ns/1ps
module amcc_checker
  import amcc_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       pce,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       port_b_data_4,
  input wire logic       timer_output_level,
  input wire logic       wait_mode,
  input wire logic       stop_mode,
  input wire logic [3:0] channel_pin_select,
  input wire logic       supply_select,
  input wire logic       half_divide_select,
  input wire logic       temp_diode_select,
  input wire logic       temp_bias_enable,
  input wire logic       ramp_source_enable,
  input wire logic       ramp_discharge_enable,
  input wire logic       shared_compare_output_pin,
  input wire logic       wake_request
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  // frozen cycles hold every output, so nothing is judged while the clock enable is low
  default disable iff (!presetn || !pce);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    ##1 pready;
  endsequence
  answer_wait_a: assert property (s_access |-> s_answer) else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  error_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  supply_chan_a: assert property (supply_select |-> channel_pin_select == 4'h0) else $error("supply with pin");
  diode_half_a: assert property (temp_diode_select |-> half_divide_select) else $error("diode without half");
  bias_follow_a: assert property (temp_bias_enable == temp_diode_select) else $error("bias mismatch");
  ramp_excl_a: assert property (!(ramp_source_enable && ramp_discharge_enable)) else $error("source and sink");
  stop_wake_a: assert property (stop_mode |=> !wake_request) else $error("wake in stop");
  wait_wake_a: assert property ($rose(wake_request) |-> $past(wait_mode)) else $error("wake outside wait");
  shared_or_a: assert property ((port_b_data_4 || timer_output_level) |=> shared_compare_output_pin)
    else $error("shared pin low");
endmodule
bind amcc_top amcc_checker u_chk (
  .pclk, .presetn, .pce, .psel, .penable, .pready, .pslverr, .port_b_data_4, .timer_output_level, .wait_mode,
  .stop_mode, .channel_pin_select, .supply_select, .half_divide_select, .temp_diode_select, .temp_bias_enable,
  .ramp_source_enable, .ramp_discharge_enable, .shared_compare_output_pin, .wake_request
);

// ### amcc_partner.sv
`timescale 1ns/1ps
module amcc_partner
  import amcc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic cmp1_req,
  input  wire logic cmp2_req,
  output logic      comparator1_out,
  output logic      comparator2_out
);
  // ---------------------------------------------------------------
  // comparators, pins kept as inputs with pulldowns off, capture masked
  // ---------------------------------------------------------------
  always @(posedge pclk)
  begin
    comparator1_out <= cmp1_req;
    comparator2_out <= cmp2_req;
  end
endmodule

// ### amcc_pkg.sv
// Function
// - With the supply reference bit set and no channel bit set, the channel bus is switched to the supply pin.
// - The divided hold bit selects the half-divided copy of the selected input.
// - Each channel select bit switches the channel bus to its own analog port B pin.
// - Both comparators stay usable in wait mode and their events can wake the processor by the analog interrupt.
// - In stop mode comparator events do not wake the processor, but comparator 1 may still drive the shared pin.
// - With the option bit and comparator 1 output enable set, the shared pin carries comparator 1 ORed with data and timer level.
// - Clearing the ramp current enable turns off both the charge source and the discharge device.
// - Comparator 1 negative input shares the capture pin, so software masks the capture interrupt when using it.
// - Ramp enable with manual mode 0 and charge enable set drives the ramp source continuously.
// - Sample hold and divided hold both set select the temperature diode.
// - The diode bias source is on only while the diode is selected.
// - In conversion methods 1 to 3 the ramp capacitor is discharged as soon as the conversion ends.
package amcc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] AMCC_IDX_MUX    = 16'h0003;
  localparam logic [15:0] AMCC_IDX_CTRL   = 16'h001d;
  localparam logic [15:0] AMCC_IDX_STAT   = 16'h001e;
  localparam logic [15:0] AMCC_IDX_IRQ_ST = 16'h0020;
  localparam logic [15:0] AMCC_IDX_IRQ_MK = 16'h0021;
  localparam logic [15:0] AMCC_IDX_OPT    = 16'h1ff0;
  localparam int          AMCC_ADDR_W     = 16;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int AMCC_MUX_CH_LSB   = 0;
  localparam int AMCC_MUX_VREF     = 4;
  localparam int AMCC_MUX_HOLD     = 5;
  localparam int AMCC_MUX_DIVIDED_HOLD    = 6;
  localparam int AMCC_CTRL_RAMP_CURRENT_ENABLE    = 0;
  localparam int AMCC_CTRL_MA      = 1;
  localparam int AMCC_CTRL_MB      = 2;
  localparam int AMCC_CTRL_CHG     = 3;
  localparam int AMCC_STAT_COMPARATOR1_OUTPUT_ENABLE    = 0;
  localparam int AMCC_STAT_CMP1    = 6;
  localparam int AMCC_STAT_CMP2    = 7;
  localparam int AMCC_OPT_EN       = 0;
  localparam int AMCC_IRQ_CMP1     = 0;
  localparam int AMCC_IRQ_CMP2     = 1;

  // ---------------------------------------------------------------
  // values after reset and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] AMCC_RST_MUX  = 8'h00;
  localparam logic [7:0] AMCC_RST_CTRL = 8'h00;
  localparam logic [7:0] AMCC_RST_STAT = 8'h00;
  localparam logic [7:0] AMCC_RST_OPT  = 8'h00;
  localparam logic [1:0] AMCC_RST_IRQ  = 2'h0;
  localparam logic [7:0] AMCC_WMSK_MUX  = 8'h7f;
  localparam logic [7:0] AMCC_WMSK_CTRL = 8'h0f;
  localparam logic [7:0] AMCC_WMSK_STAT = 8'h01;
  localparam logic [7:0] AMCC_WMSK_OPT  = 8'h01;

endpackage

// ### amcc_sync2.sv
`timescale 1ns/1ps
module amcc_sync2
  import amcc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pce,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);

  typedef struct packed
  {
    logic [1:0] meta;
    logic [1:0] sync;
  } amcc_sync_s;

  amcc_sync_s st_r;
  amcc_sync_s st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.meta = async_in;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else if (pce)
      st_r <= st_nxt;
  end

  assign sync_out = st_r.sync;

endmodule

// ### amcc_tb_top.sv
`timescale 1ns/1ps
module amcc_tb_top
  import amcc_pkg::*;
();
  // ---------------------------------------------------------------
  // stimulus and tables
  // ---------------------------------------------------------------
  // hold bits change only in writes that keep the channel as it is
  localparam logic [7:0]  MUX_W [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h11, 8'h41, 8'h61, 8'h21};
  localparam logic [7:0]  MUX_E [9] = '{8'h10, 8'h20, 8'h40, 8'h80, 8'h08, 8'h10, 8'h14, 8'h17, 8'h10};
  localparam logic [8:0]  RMP_W [9] = '{9'h008, 9'h009, 9'h001, 9'h103, 9'h003, 9'h105, 9'h005, 9'h107, 9'h007};
  localparam logic [1:0]  RMP_E [9] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
  localparam logic [15:0] REGS [6]  = '{AMCC_IDX_MUX, AMCC_IDX_CTRL, AMCC_IDX_STAT, AMCC_IDX_IRQ_ST,
                                        AMCC_IDX_IRQ_MK, AMCC_IDX_OPT};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        cmp1 = 1'b0, cmp2 = 1'b0, pb4 = 1'b0, tlvl = 1'b0, conv = 1'b0, waitm = 1'b0, stopm = 1'b0;
  logic        pce = 1'b1;
  logic [3:0]  chan;
  logic        pready, pslverr, err, c1o, c2o, sup, half, diode, bias, src, dis, pin, irq, wake;
  int          n_mismatch = 0;
  int          total_checks = 0;

  initial
  begin
    forever #2.5 pclk = ~pclk;
  end

  amcc_partner u_far (.pclk(pclk), .cmp1_req(cmp1), .cmp2_req(cmp2), .comparator1_out(c1o), .comparator2_out(c2o));
  amcc_top dut (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator1_out(c1o), .comparator2_out(c2o), .port_b_data_4(pb4), .timer_output_level(tlvl),
    .conversion_active(conv), .wait_mode(waitm), .stop_mode(stopm), .channel_pin_select(chan),
    .supply_select(sup), .half_divide_select(half), .temp_diode_select(diode), .temp_bias_enable(bias),
    .ramp_source_enable(src), .ramp_discharge_enable(dis), .shared_compare_output_pin(pin),
    .analog_irq(irq), .wake_request(wake)
  );

  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      conclude;
    end
  endtask

  task step;
    @(posedge pclk);
    #1;
  endtask

  task pin_case(input logic c, input logic d, input logic t, input logic e);
    @(posedge pclk);
    cmp1 <= c;
    pb4 <= d;
    tlvl <= t;
    repeat (6) step;
    chk({31'h0, pin}, {31'h0, e});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task s_regs;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, REGS[i], 32'h0);
      chk(rd, 32'h0);
    end
    chk({19'h0, chan, sup, half, diode, bias, src, dis, pin, irq, wake}, 32'h0);
    apb(1'b0, 16'h0004, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task s_mux;
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, AMCC_IDX_MUX, {24'h0, MUX_W[i]});
      step;
      chk({24'h0, chan, sup, half, diode, bias}, {24'h0, MUX_E[i]});
    end
  endtask

  task s_ramp;
    for (int i = 0; i < 9; i++)
    begin
      @(posedge pclk);
      conv <= RMP_W[i][8];
      apb(1'b1, AMCC_IDX_CTRL, {24'h0, RMP_W[i][7:0]});
      step;
      chk({30'h0, src, dis}, {30'h0, RMP_E[i]});
    end
  endtask

  task s_shared;
    apb(1'b1, AMCC_IDX_STAT, 32'h1);
    pin_case(1'b1, 1'b0, 1'b0, 1'b0);
    apb(1'b1, AMCC_IDX_OPT, 32'h1);
    pin_case(1'b1, 1'b0, 1'b0, 1'b1);
    pin_case(1'b0, 1'b1, 1'b0, 1'b1);
    pin_case(1'b0, 1'b0, 1'b1, 1'b1);
    pin_case(1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge pclk);
    stopm <= 1'b1;
    pin_case(1'b1, 1'b0, 1'b0, 1'b1);
    apb(1'b1, AMCC_IDX_STAT, 32'h0);
    pin_case(1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge pclk);
    stopm <= 1'b0;
  endtask

  task s_irq;
    @(posedge pclk);
    cmp1 <= 1'b0;
    apb(1'b1, AMCC_IDX_IRQ_ST, 32'h3);
    @(posedge pclk);
    cmp2 <= 1'b1;
    repeat (8) step;
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, AMCC_IDX_IRQ_ST, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, AMCC_IDX_IRQ_MK, 32'h3);
    waitm <= 1'b1;
    repeat (3) step;
    chk({30'h0, irq, wake}, 32'h3);
    @(posedge pclk);
    stopm <= 1'b1;
    repeat (3) step;
    chk({30'h0, irq, wake}, 32'h2);
    apb(1'b1, AMCC_IDX_IRQ_ST, 32'h2);
    repeat (3) step;
    chk({30'h0, irq, wake}, 32'h0);
    apb(1'b1, AMCC_IDX_STAT, 32'hff);
    apb(1'b0, AMCC_IDX_STAT, 32'h0);
    chk(rd, 32'h81);
  endtask

  task s_freeze;
    @(posedge pclk);
    pce <= 1'b0;
    pb4 <= 1'b1;
    repeat (4) step;
    chk({31'h0, pin}, 32'h0);
    @(posedge pclk);
    pce <= 1'b1;
    repeat (2) step;
    chk({31'h0, pin}, 32'h1);
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    s_regs;
    s_mux;
    s_ramp;
    s_shared;
    s_irq;
    s_freeze;
    conclude;
  end
endmodule

// ### amcc_top.sv
`timescale 1ns/1ps
module amcc_top
  import amcc_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   pce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [AMCC_ADDR_W+1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   comparator1_out,
  input  wire logic                   comparator2_out,
  input  wire logic                   port_b_data_4,
  input  wire logic                   timer_output_level,
  input  wire logic                   conversion_active,
  input  wire logic                   wait_mode,
  input  wire logic                   stop_mode,
  output logic      [3:0]             channel_pin_select,
  output logic                        supply_select,
  output logic                        half_divide_select,
  output logic                        temp_diode_select,
  output logic                        temp_bias_enable,
  output logic                        ramp_source_enable,
  output logic                        ramp_discharge_enable,
  output logic                        shared_compare_output_pin,
  output logic                        analog_irq,
  output logic                        wake_request
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0]  mux;
    logic [7:0]  ctrl;
    logic [7:0]  stat;
    logic [7:0]  option_enable;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mk;
    logic [1:0]  cmp_d;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [3:0]  ch_sel;
    logic        sup_sel;
    logic        half_sel;
    logic        temp_sel;
    logic        temp_bias;
    logic        ramp_src;
    logic        ramp_dis;
    logic        cmp_pin;
    logic        irq;
    logic        wake;
  } amcc_state_s;

  amcc_state_s st_r;
  amcc_state_s st_nxt;
  logic [1:0]  cmp_sync;

  function automatic logic [7:0] amcc_wr(input logic [7:0] cur, input logic [7:0] wd, input logic [7:0] msk);
    amcc_wr = (cur & ~msk) | (wd & msk);
  endfunction

  function automatic logic amcc_hit(input logic [AMCC_ADDR_W+1:0] a, input logic [15:0] idx);
    amcc_hit = (a[1:0] == 2'h0) && (a[AMCC_ADDR_W+1:2] == idx);
  endfunction

  // ---------------------------------------------------------------
  // comparator inputs cross into the clock domain
  // ---------------------------------------------------------------
  amcc_sync2 u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .pce      (pce),
    .async_in ({comparator2_out, comparator1_out}),
    .sync_out (cmp_sync)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic       access;
    logic       commit;
    logic       mapped;
    logic [1:0] rise;
    logic [1:0] w1c;
    logic [1:0] mode;
    logic       ramp_current_enable;
    logic       conv_m0;
    logic       opt_coe;
    access  = 1'b0;
    commit  = 1'b0;
    mapped  = 1'b0;
    rise    = 2'h0;
    w1c     = 2'h0;
    mode    = 2'h0;
    ramp_current_enable    = 1'b0;
    conv_m0 = 1'b0;
    opt_coe = 1'b0;
    st_nxt  = st_r;

    mapped = amcc_hit(paddr, AMCC_IDX_MUX) || amcc_hit(paddr, AMCC_IDX_CTRL) ||
             amcc_hit(paddr, AMCC_IDX_STAT) || amcc_hit(paddr, AMCC_IDX_IRQ_ST) ||
             amcc_hit(paddr, AMCC_IDX_IRQ_MK) || amcc_hit(paddr, AMCC_IDX_OPT);

    // one wait state: answer prepared in the first access cycle
    access = psel && penable && !st_r.ready;
    commit = psel && penable && st_r.ready;
    st_nxt.ready = access;
    if (access)
    begin
      st_nxt.err   = !mapped;
      st_nxt.rdata = 32'h0000_0000;
      if (!pwrite)
      begin
        if (amcc_hit(paddr, AMCC_IDX_MUX))
          st_nxt.rdata[7:0] = st_r.mux;
        else if (amcc_hit(paddr, AMCC_IDX_CTRL))
          st_nxt.rdata[7:0] = st_r.ctrl;
        else if (amcc_hit(paddr, AMCC_IDX_STAT))
          st_nxt.rdata[7:0] = st_r.stat;
        else if (amcc_hit(paddr, AMCC_IDX_IRQ_ST))
          st_nxt.rdata[1:0] = st_r.irq_st;
        else if (amcc_hit(paddr, AMCC_IDX_IRQ_MK))
          st_nxt.rdata[1:0] = st_r.irq_mk;
        else if (amcc_hit(paddr, AMCC_IDX_OPT))
          st_nxt.rdata[7:0] = st_r.option_enable;
      end
    end
    else if (commit)
    begin
      st_nxt.err = 1'b0;
    end

    // writes land at the edge that completes the transfer
    if (commit && pwrite)
    begin
      if (amcc_hit(paddr, AMCC_IDX_MUX))
        st_nxt.mux = amcc_wr(st_r.mux, pwdata[7:0], AMCC_WMSK_MUX);
      if (amcc_hit(paddr, AMCC_IDX_CTRL))
        st_nxt.ctrl = amcc_wr(st_r.ctrl, pwdata[7:0], AMCC_WMSK_CTRL);
      if (amcc_hit(paddr, AMCC_IDX_STAT))
        st_nxt.stat = amcc_wr(st_r.stat, pwdata[7:0], AMCC_WMSK_STAT);
      if (amcc_hit(paddr, AMCC_IDX_OPT))
        st_nxt.option_enable = amcc_wr(st_r.option_enable, pwdata[7:0], AMCC_WMSK_OPT);
      if (amcc_hit(paddr, AMCC_IDX_IRQ_MK))
        st_nxt.irq_mk = pwdata[1:0];
      if (amcc_hit(paddr, AMCC_IDX_IRQ_ST))
        w1c = pwdata[1:0];
    end

    // live comparator levels, read-only in the status register
    st_nxt.stat[AMCC_STAT_CMP1] = cmp_sync[0];
    st_nxt.stat[AMCC_STAT_CMP2] = cmp_sync[1];

    // comparators keep running in every mode; rising edges are events
    st_nxt.cmp_d  = cmp_sync;
    rise          = cmp_sync & ~st_r.cmp_d;
    st_nxt.irq_st = (st_r.irq_st & ~w1c) | rise;
    st_nxt.irq    = |(st_nxt.irq_st & st_r.irq_mk);
    // wake from wait only, never directly from stop
    st_nxt.wake   = st_nxt.irq && wait_mode && !stop_mode;

    // analog switch decode from the register values being stored
    st_nxt.ch_sel   = st_nxt.mux[AMCC_MUX_CH_LSB +: 4];
    st_nxt.sup_sel  = st_nxt.mux[AMCC_MUX_VREF] && (st_nxt.mux[AMCC_MUX_CH_LSB +: 4] == 4'h0);
    st_nxt.half_sel = st_nxt.mux[AMCC_MUX_DIVIDED_HOLD];
    st_nxt.temp_sel = st_nxt.mux[AMCC_MUX_HOLD] && st_nxt.mux[AMCC_MUX_DIVIDED_HOLD];
    st_nxt.temp_bias = st_nxt.temp_sel;

    // ramp current source and discharge device
    ramp_current_enable    = st_nxt.ctrl[AMCC_CTRL_RAMP_CURRENT_ENABLE];
    mode    = {st_nxt.ctrl[AMCC_CTRL_MB], st_nxt.ctrl[AMCC_CTRL_MA]};
    conv_m0 = (mode == 2'h0);
    if (!ramp_current_enable)
    begin
      st_nxt.ramp_src = 1'b0;
      st_nxt.ramp_dis = 1'b0;
    end
    else if (conv_m0)
    begin
      st_nxt.ramp_src = st_nxt.ctrl[AMCC_CTRL_CHG];
      st_nxt.ramp_dis = !st_nxt.ctrl[AMCC_CTRL_CHG];
    end
    else
    begin
      // automatic methods discharge as soon as the conversion stops
      st_nxt.ramp_src = conversion_active;
      st_nxt.ramp_dis = !conversion_active;
    end

    // shared compare pin: data and timer level, plus comparator 1 when enabled
    opt_coe = st_nxt.option_enable[AMCC_OPT_EN] && st_nxt.stat[AMCC_STAT_COMPARATOR1_OUTPUT_ENABLE];
    st_nxt.cmp_pin = port_b_data_4 || timer_output_level || (opt_coe && cmp_sync[0]);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r        <= '0;
      st_r.mux    <= AMCC_RST_MUX;
      st_r.ctrl   <= AMCC_RST_CTRL;
      st_r.stat   <= AMCC_RST_STAT;
      st_r.option_enable    <= AMCC_RST_OPT;
      st_r.irq_st <= AMCC_RST_IRQ;
      st_r.irq_mk <= AMCC_RST_IRQ;
    end
    else if (pce)
      st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata                    = st_r.rdata;
  assign pready                    = st_r.ready;
  assign pslverr                   = st_r.err;
  assign channel_pin_select        = st_r.ch_sel;
  assign supply_select             = st_r.sup_sel;
  assign half_divide_select        = st_r.half_sel;
  assign temp_diode_select         = st_r.temp_sel;
  assign temp_bias_enable          = st_r.temp_bias;
  assign ramp_source_enable        = st_r.ramp_src;
  assign ramp_discharge_enable     = st_r.ramp_dis;
  assign shared_compare_output_pin = st_r.cmp_pin;
  assign analog_irq                = st_r.irq;
  assign wake_request              = st_r.wake;

endmodule
